// [hdl/serial_status_readout.sv]
// Serial status readout clocked by the mode-control pin
//
// Behaviour
// - Host toggles mode pin, bits follow edges
// - Output low for set bit, high clear
// - Access when io flag clear, high range
// - Access when core flag clear, low range
// - Idle timeout clears gone sticky bits S4-S10
// - S0 mirrors pin wake source flag
// - S1 mirrors line wake source flag
// - S2 always reads set
// - S11 and S12 always read clear
// - S3 records supply-up flag
// - S4 latches bus mismatch flag
// - S5 latches overheat flag
// - S6 latches heat warning flag
// - S7 latches transmit gate stuck flag
// - S8-S10 latch the three undervoltage flags
// - Pin wake flag: low power only, cleared entering
// - Supply-up flag cleared entering normal mode
// - Heat warning cleared by low-power read with battery in range
// - Summary error follows S4 to S10
`timescale 1ns/10ps
`default_nettype none
module serial_status_readout
(
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic mode_clock_in,
  input  wire logic pin_wake_event_in,
  input  wire logic line_wake_source_flag_in,
  input  wire logic bus_mismatch_flag_in,
  input  wire logic overheat_flag_in,
  input  wire logic temp_above_warn_in,
  input  wire logic transmit_gate_stuck_flag_in,
  input  wire logic battery_undervolt_flag_in,
  input  wire logic core_supply_undervolt_flag_in,
  input  wire logic io_supply_undervolt_flag_in,
  input  wire logic io_supply_high_range_in,
  input  wire logic io_supply_low_range_in,
  input  wire logic low_power_mode_in,
  input  wire logic normal_mode_in,
  input  wire logic battery_in_range_in,
  output logic      fault_serial_out_low_out,
  output logic      error_summary_out,
  output logic      pin_wake_source_flag_out,
  output logic      supply_up_flag_out,
  output logic      heat_warning_flag_out
);
  import status_readout_pkg::*;

  // ==========================================================
  // Reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================================
  // Input synchronisers
  // All pin-side levels pass two flops; only the second is read
  logic [IN_W-1:0] raw_in;
  logic [IN_W-1:0] sync_meta;
  logic [IN_W-1:0] sync_q;
  logic            mode_clk_prev;
  logic            low_power_prev;
  logic            normal_prev;

  assign raw_in = {mode_clock_in, pin_wake_event_in, battery_in_range_in, normal_mode_in,
                   low_power_mode_in, io_supply_low_range_in, io_supply_high_range_in,
                   io_supply_undervolt_flag_in, core_supply_undervolt_flag_in,
                   battery_undervolt_flag_in, transmit_gate_stuck_flag_in, temp_above_warn_in,
                   overheat_flag_in, bus_mismatch_flag_in, line_wake_source_flag_in};

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_meta      <= '0;
      sync_q         <= '0;
      mode_clk_prev  <= 1'b0;
      low_power_prev <= 1'b0;
      normal_prev    <= 1'b0;
    end
    else
    begin
      sync_meta      <= raw_in;
      sync_q         <= sync_meta;
      mode_clk_prev  <= sync_q[IN_MODE_CLK];
      low_power_prev <= sync_q[IN_LOW_POWER];
      normal_prev    <= sync_q[IN_NORMAL];
    end
  end

  // ==========================================================
  // Decoded conditions
  wire low_power_s   = sync_q[IN_LOW_POWER];
  wire bat_ok_s      = sync_q[IN_BAT_OK];
  wire en_edge       = sync_q[IN_MODE_CLK] ^ mode_clk_prev;
  wire low_power_ent = low_power_s & ~low_power_prev;
  wire normal_ent    = sync_q[IN_NORMAL] & ~normal_prev;
  wire access_hi     = ~sync_q[IN_IO_UV] & sync_q[IN_IO_HIGH];
  wire access_lo     = ~sync_q[IN_CORE_UV] & sync_q[IN_IO_LOW];
  wire access_ok     = access_hi | access_lo;

  // ==========================================================
  // Readout sequencer
  read_state_t               state;
  read_state_t               next_state;
  logic [STATUS_W-1:0]       shift_q;
  logic [BIT_CNT_W-1:0]      bit_count;
  logic [IDLE_CNT_W-1:0]     idle_count;
  logic                      clear_pulse;
  logic [STATUS_W-1:0]       status_vec;

  wire in_idle      = (state == ST_IDLE);
  wire start_read   = in_idle & en_edge & access_ok;
  wire shift_edge   = (state == ST_SHIFT) & en_edge;
  // silence longer than the idle time
  wire idle_expired = (state == ST_SHIFT) & ~en_edge & (idle_count == EN_IDLE_CYCLES);

  assign next_state = start_read   ? ST_SHIFT :
                      idle_expired ? ST_IDLE  : state;

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // Idle timer restarts on every edge seen during a readout
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      idle_count <= '0;
    else if (in_idle | en_edge)
      idle_count <= '0;
    else if (idle_count != EN_IDLE_CYCLES)
      idle_count <= idle_count + 13'h1;
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      clear_pulse <= 1'b0;
    else
      clear_pulse <= idle_expired;
  end

  // snapshot then shift out S0 first
  // Snapshot is taken once so a bit cannot change mid-read
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_q   <= '0;
      bit_count <= '0;
    end
    else if (start_read)
    begin
      shift_q   <= {1'b0, status_vec[STATUS_W-1:1]};
      bit_count <= '0;
    end
    else if (shift_edge)
    begin
      shift_q <= {1'b0, shift_q[STATUS_W-1:1]};
      if (bit_count != LAST_BIT)
        bit_count <= bit_count + 4'h1;
    end
  end

  // low drive for a set bit
  // Beyond the thirteenth edge zeros shift in, so the pin rests high
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      fault_serial_out_low_out <= 1'b1;
    else if (start_read)
      fault_serial_out_low_out <= ~status_vec[BIT_PIN_WAKE];
    else if (shift_edge)
      fault_serial_out_low_out <= ~shift_q[0];
    else if (in_idle)
      fault_serial_out_low_out <= 1'b1;
  end

  // ==========================================================
  // Device flags kept here
  logic pin_wake_flag;
  logic supply_up_flag;
  logic heat_warn_flag;

  // set only in low power, cleared on entry
  wire pin_wake_set = sync_q[IN_WAKE_EVT] & low_power_s;
  // read in low power with battery in range clears heat warning
  wire heat_set     = sync_q[IN_TEMP_WARN] & ~low_power_s & bat_ok_s;
  wire heat_clr     = (~sync_q[IN_TEMP_WARN] & ~low_power_s & bat_ok_s) |
                      (clear_pulse & low_power_s & bat_ok_s);

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_wake_flag  <= 1'b0;
      supply_up_flag <= 1'b1;
      heat_warn_flag <= 1'b0;
    end
    else
    begin
      pin_wake_flag  <= pin_wake_set | (pin_wake_flag & ~low_power_ent);
      supply_up_flag <= supply_up_flag & ~normal_ent;
      heat_warn_flag <= heat_set | (heat_warn_flag & ~heat_clr);
    end
  end

  // ==========================================================
  // Sticky status bits S3 to S10
  logic [STICKY_HI:STICKY_LO] flag_vec;
  logic [STICKY_HI:STICKY_LO] sticky;

  assign flag_vec[BIT_SUPPLY_UP]  = supply_up_flag;
  assign flag_vec[BIT_MISMATCH]   = sync_q[IN_MISMATCH];
  assign flag_vec[BIT_OVERHEAT]   = sync_q[IN_OVERHEAT];
  assign flag_vec[BIT_HEAT_WARN]  = heat_warn_flag;
  assign flag_vec[BIT_GATE_STUCK] = sync_q[IN_GATE_STUCK];
  // S8 to S10 from undervoltage flags
  assign flag_vec[BIT_BAT_UV]     = sync_q[IN_BAT_UV];
  assign flag_vec[BIT_CORE_UV]    = sync_q[IN_CORE_UV];
  assign flag_vec[BIT_IO_UV]      = sync_q[IN_IO_UV];

  genvar gi;
  generate
    for (gi = STICKY_LO; gi <= STICKY_HI; gi++)
    begin : g_sticky
      // only S4 upward clear on timeout
      wire clr_here = (gi >= CLEARABLE_LO) ? clear_pulse : 1'b0;
      sticky_status_bit u_bit
      (
        .clk_in     (clk_in),
        .rst_n_in   (rst_n),
        .flag_in    (flag_vec[gi]),
        .clear_in   (clr_here),
        .sticky_out (sticky[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Status word
  // live wake bits; S2 set; top bits clear
  assign status_vec = {UNUSED_HIGH_BITS, sticky, UNUSED_SET_VAL,
                       sync_q[IN_LINE_WAKE], pin_wake_flag};

  wire error_now = |sticky[STICKY_HI:CLEARABLE_LO];

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      error_summary_out        <= 1'b0;
      pin_wake_source_flag_out <= 1'b0;
      supply_up_flag_out       <= 1'b1;
      heat_warning_flag_out    <= 1'b0;
    end
    else
    begin
      error_summary_out        <= error_now;
      pin_wake_source_flag_out <= pin_wake_flag;
      supply_up_flag_out       <= supply_up_flag;
      heat_warning_flag_out    <= heat_warn_flag;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  chk_first_bit_out: assert property (start_read |=> fault_serial_out_low_out == !$past(status_vec[0]))
    else $error("first bit not S0");
  chk_idle_rests_high: assert property (in_idle && !en_edge |=> fault_serial_out_low_out)
    else $error("pin not high while idle");
  chk_unused_set: assert property (start_read |=> shift_q[1])
    else $error("S2 not set in snapshot");
  chk_unused_clear: assert property (start_read |=> shift_q[11:10] == 2'h0)
    else $error("S11 or S12 set in snapshot");
  chk_no_access: assert property (in_idle && !access_ok |=> state == ST_IDLE)
    else $error("readout started without access");
  chk_mismatch_latch: assert property (sync_q[IN_MISMATCH] |=> sticky[BIT_MISMATCH])
    else $error("mismatch not latched");
  chk_timeout_clear: assert property (clear_pulse && !flag_vec[BIT_OVERHEAT] |=> !sticky[BIT_OVERHEAT])
    else $error("sticky bit not cleared on timeout");
  chk_supply_keep: assert property (clear_pulse && sticky[BIT_SUPPLY_UP] |=> sticky[BIT_SUPPLY_UP])
    else $error("S3 cleared by timeout");
  chk_wake_entry_clear: assert property (low_power_ent && !sync_q[IN_WAKE_EVT] |=> !pin_wake_flag)
    else $error("pin wake flag kept on entry");
  chk_supply_normal: assert property (normal_ent |=> !supply_up_flag)
    else $error("supply-up flag kept in normal");
  chk_error_follow: assert property (error_now |=> error_summary_out)
    else $error("summary error missed");
  chk_timeout_delay: assert property ($rose(state == ST_SHIFT) ##0 !en_edge [*4] |-> state == ST_SHIFT)
    else $error("readout ended too early");

  cov_start_read: cover property (start_read);
  cov_full_read: cover property (shift_edge && bit_count == LAST_BIT - 4'h1);
  cov_timeout: cover property (clear_pulse);
  cov_refused: cover property (in_idle && en_edge && !access_ok);

endmodule
`default_nettype wire

// [hdl/status_readout_pkg.sv]
// Constants shared by the serial status readout block
package status_readout_pkg;

  // ==========================================================
  // Status word layout
  localparam int unsigned STATUS_W     = 13;
  localparam int unsigned BIT_PIN_WAKE = 0;
  localparam int unsigned BIT_LINE_WAKE = 1;
  localparam int unsigned BIT_UNUSED_SET = 2;
  localparam int unsigned BIT_SUPPLY_UP = 3;
  localparam int unsigned BIT_MISMATCH  = 4;
  localparam int unsigned BIT_OVERHEAT  = 5;
  localparam int unsigned BIT_HEAT_WARN = 6;
  localparam int unsigned BIT_GATE_STUCK = 7;
  localparam int unsigned BIT_BAT_UV    = 8;
  localparam int unsigned BIT_CORE_UV   = 9;
  localparam int unsigned BIT_IO_UV     = 10;
  localparam int unsigned STICKY_LO     = 3;
  localparam int unsigned STICKY_HI     = 10;
  localparam int unsigned CLEARABLE_LO  = 4;
  localparam logic [1:0]  UNUSED_HIGH_BITS = 2'h0;
  localparam logic        UNUSED_SET_VAL   = 1'h1;

  // ==========================================================
  // Asynchronous input vector positions
  localparam int unsigned IN_W          = 15;
  localparam int unsigned IN_LINE_WAKE  = 0;
  localparam int unsigned IN_MISMATCH   = 1;
  localparam int unsigned IN_OVERHEAT   = 2;
  localparam int unsigned IN_TEMP_WARN  = 3;
  localparam int unsigned IN_GATE_STUCK = 4;
  localparam int unsigned IN_BAT_UV     = 5;
  localparam int unsigned IN_CORE_UV    = 6;
  localparam int unsigned IN_IO_UV      = 7;
  localparam int unsigned IN_IO_HIGH    = 8;
  localparam int unsigned IN_IO_LOW     = 9;
  localparam int unsigned IN_LOW_POWER  = 10;
  localparam int unsigned IN_NORMAL     = 11;
  localparam int unsigned IN_BAT_OK     = 12;
  localparam int unsigned IN_WAKE_EVT   = 13;
  localparam int unsigned IN_MODE_CLK   = 14;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS    = 25;
  localparam int unsigned EN_IDLE_TIME_NS  = 100000;
  localparam int unsigned EN_IDLE_CYCLES_I = (EN_IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned IDLE_CNT_W       = 13;
  localparam logic [IDLE_CNT_W-1:0] EN_IDLE_CYCLES = EN_IDLE_CYCLES_I[IDLE_CNT_W-1:0];
  localparam int unsigned BIT_CNT_W        = 4;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'hc;

  // ==========================================================
  // Readout states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } read_state_t;

endpackage

// [hdl/sticky_status_bit.sv]
// One sticky status bit: set by its flag, cleared on request when the flag is gone
`timescale 1ns/10ps
`default_nettype none
module sticky_status_bit
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic flag_in,
  input  wire logic clear_in,
  output logic      sticky_out
);

  // ==========================================================
  // Storage
  // Set wins over clear so an event in the clear cycle survives
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      sticky_out <= 1'b0;
    else if (flag_in)
      sticky_out <= 1'b1;
    else if (clear_in)
      sticky_out <= 1'b0;
  end

endmodule
`default_nettype wire

// [sim/status_host.sv]
// Host model that clocks the mode pin and collects the status bits
`timescale 1ns/10ps
`default_nettype none
module status_host
(
  input  wire logic status_in,
  output var logic  mode_clock_out
);
  // ==========================================================
  // Idle level
  // The pin stands still between readouts
  initial mode_clock_out = 1'h0;

  // ==========================================================
  // Readout
  // Edges 100 ns apart; a bit is taken 50 ns after the following edge,
  // which clears the sync and edge-detect delay with margin either side
  // one bit per pin edge, S0 first
  task automatic read_word(output logic [12:0] word);
    int i;
    word = '0;
    #7;
    for (i = 0; i < 14; i++)
    begin
      if (i < 13)
        mode_clock_out = ~mode_clock_out;
      #50;
      if (i > 0)
        word[i-1] = ~status_in;
      #50;
    end
  endtask
endmodule
`default_nettype wire

// [sim/tb_serial_status_readout.sv]
// Testbench for the serial status readout block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("CHECK FAILED t=%0t %s", $time, msg); end end
module tb_serial_status_readout;
  import status_readout_pkg::*;
  logic        clk_in    = 1'h0;
  logic        nrst_in   = 1'h0;
  logic        wake_evt  = 1'h0;
  logic        line_wake = 1'h0;
  logic        io_hi     = 1'h1;
  logic        low_pwr   = 1'h0;
  logic        normal    = 1'h0;
  logic        bat_ok    = 1'h1;
  logic [10:4] fl        = '0;
  logic [10:4] v;
  logic [10:4] k;
  logic        mode_clock;
  logic        ser_low;
  logic        err_sum;
  logic        pin_wake;
  logic        sup_up;
  logic        heat;
  logic [12:0] word;
  logic [12:0] exp_w;
  int          n_errors = 0;
  int          checked  = 0;
  int          st [0:12];
  int          i;
  int          it;
  int          acc;

  always #12.5 clk_in = ~clk_in;

  serial_status_readout dut_u
  (
    .clk_in                        (clk_in),
    .nrst_in                       (nrst_in),
    .mode_clock_in                 (mode_clock),
    .pin_wake_event_in             (wake_evt),
    .line_wake_source_flag_in      (line_wake),
    .bus_mismatch_flag_in          (fl[4]),
    .overheat_flag_in              (fl[5]),
    .temp_above_warn_in            (fl[6]),
    .transmit_gate_stuck_flag_in   (fl[7]),
    .battery_undervolt_flag_in     (fl[8]),
    .core_supply_undervolt_flag_in (fl[9]),
    .io_supply_undervolt_flag_in   (fl[10]),
    .io_supply_high_range_in       (io_hi),
    .io_supply_low_range_in        (~io_hi),
    .low_power_mode_in             (low_pwr),
    .normal_mode_in                (normal),
    .battery_in_range_in           (bat_ok),
    .fault_serial_out_low_out      (ser_low),
    .error_summary_out             (err_sum),
    .pin_wake_source_flag_out      (pin_wake),
    .supply_up_flag_out            (sup_up),
    .heat_warning_flag_out         (heat)
  );

  status_host host_u
  (
    .status_in      (ser_low),
    .mode_clock_out (mode_clock)
  );

  // ==========================================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic complete_run;
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // A refused readout leaves the pin high, so every bit reads clear
  task automatic read_check(input int ok);
    int b;
    for (b = 0; b < 13; b++)
      exp_w[b] = (ok != 0) && (st[b] != 0);
    host_u.read_word(word);
    for (b = 0; b < 13; b++)
      `CHK(word[b], exp_w[b], "status bit")
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    void'($urandom(32'hf8ce64ab));
    for (i = 0; i < 13; i++)
      st[i] = 0;
    st[2] = 1;
    st[3] = 1;
    cyc(10);
    nrst_in <= 1'h1;
    cyc(10);
    `CHK(sup_up, 1'h1, "supply up after reset")
    read_check(1);
    // Let the readout time out before the next one may start
    cyc(4110);
    for (it = 0; it < 4; it++)
    begin
      v = 7'($urandom);
      k = v & 7'($urandom);
      @(posedge clk_in);
      fl        <= v;
      line_wake <= 1'($urandom);
      io_hi     <= 1'($urandom);
      cyc(12);
      if (it == 1)
      begin
        k[9]  = 1'h0;
        io_hi <= 1'h0;
      end
      if (it == 2)
      begin
        k[10] = 1'h0;
        io_hi <= 1'h1;
      end
      if (it == 3)
        k[10:9] = 2'h3;
      fl <= k;
      cyc(12);
      st[1] = line_wake;
      for (i = 4; i < 11; i++)
        st[i] = st[i] | v[i] | k[i];
      `CHK(heat, k[6], "heat flag follows temperature")
      acc = (!k[10] && io_hi) || (!k[9] && !io_hi);
      // latched bits, access by supply range
      read_check(acc);
      cyc(4110);
      // timeout clears bits whose flag is gone
      if (acc != 0)
        for (i = 4; i < 11; i++)
          if (!k[i])
            st[i] = 0;
      exp_w[0] = 1'h0;
      for (i = 4; i < 11; i++)
        exp_w[0] = exp_w[0] | (st[i] != 0);
      `CHK(err_sum, exp_w[0], "error summary")
    end
    @(posedge clk_in);
    fl       <= '0;
    wake_evt <= 1'h1;
    cyc(10);
    `CHK(pin_wake, 1'h0, "pin wake outside low power")
    low_pwr  <= 1'h1;
    wake_evt <= 1'h0;
    cyc(10);
    wake_evt <= 1'h1;
    cyc(10);
    `CHK(pin_wake, 1'h1, "pin wake in low power")
    low_pwr <= 1'h0;
    normal  <= 1'h1;
    io_hi   <= 1'h1;
    cyc(10);
    `CHK(sup_up, 1'h0, "supply up cleared by normal mode")
    st[0] = 1;
    st[1] = line_wake;
    // pin wake shown live, supply-up record kept
    read_check(1);
    cyc(4110);
    // All flags are low now, so the timeout empties S4 to S10
    for (i = 4; i < 11; i++)
      st[i] = 0;
    fl[6] <= 1'h1;
    cyc(10);
    fl[6]    <= 1'h0;
    low_pwr  <= 1'h1;
    normal   <= 1'h0;
    wake_evt <= 1'h0;
    bat_ok   <= 1'h0;
    cyc(10);
    `CHK(heat, 1'h1, "heat flag held in low power")
    st[0] = 0;
    st[6] = 1;
    read_check(1);
    cyc(4110);
    `CHK(heat, 1'h1, "heat flag kept without battery range")
    bat_ok <= 1'h1;
    cyc(10);
    read_check(1);
    cyc(4110);
    `CHK(heat, 1'h0, "heat flag cleared by low-power read")
    complete_run();
  end
endmodule
`default_nettype wire
